// [hdl/tsf_pair_buf.sv]
module tsf_pair_buf #(
  parameter int WIDTH = 2
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  // -----------------------------------------------------------------
  // two-entry store
  // -----------------------------------------------------------------
  logic [WIDTH-1:0] slot [0:1];
  logic wr_ptr;
  logic rd_ptr;
  logic [1:0] count;
  logic push;
  logic pop;

  // honest full and empty
  assign in_ready = (count != 2'd2);
  assign out_valid = (count != 2'd0);
  assign out_data = slot[rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // entry writes
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      slot[0] <= '0;
      slot[1] <= '0;
    end else if (push) begin
      slot[wr_ptr] <= in_data;
    end
  end

  // pointers and occupancy
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count <= 2'd0;
    end else begin
      if (push) begin
        wr_ptr <= ~wr_ptr;
      end
      if (pop) begin
        rd_ptr <= ~rd_ptr;
      end
      case ({push, pop})
        2'b10: count <= count + 2'd1;
        2'b01: count <= count - 2'd1;
        default: count <= count;
      endcase
    end
  end

endmodule

// [hdl/tsf_pkg.sv]
// Overview of operation
// - set underflow (bit 3) when transmitter wants data and none waits.
// - underflow never rises before at least one bit has been sent.
// - reading the event status register clears underflow, overflow and done.
// - set overflow (bit 2) when data is written before previous byte was sent.
// - set done (bit 1) when a byte finishes and no further data waits.
// - done rises only after at least one bit has been sent.
// - empty (bit 0) sets on load into shifter, clears on data write.
// - flags set and readable regardless of interrupt-enable settings.
// - all transmit flags read zero while not in transmit mode.
// - event status register is read-only; bits 7:4 read zero.
// - each data byte goes out bit 0 first, its highest valid bit last.
// - each valid-mask bit marks its data bit valid (1) or invalid (0).
// - 64-bit spreading code in eight byte registers, low byte lowest address.
// - valid bit sends data, invalid sends preamble; shift until no valid left.
// - code spreads each bit, 64 chips or 32-chip half, chip 0 first.
// - interrupt-enable register holds one enable per flag, same positions.
package tsf_pkg;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [5:0] ADDR_TX_IRQ_EN = 6'h0D;
  localparam logic [5:0] ADDR_TX_EVENT_FLAGS = 6'h0E;
  localparam logic [5:0] ADDR_TX_DATA_BYTE = 6'h0F;
  localparam logic [5:0] ADDR_TX_BIT_VALID_MASK = 6'h10;
  localparam logic [5:0] ADDR_CODE_FIRST = 6'h11;
  localparam logic [5:0] ADDR_CODE_LAST = 6'h18;

  // ---------------------------------------------------------------
  // flag positions and reset values
  // ---------------------------------------------------------------
  localparam int FLAG_EMPTY = 0;
  localparam int FLAG_DONE = 1;
  localparam int FLAG_OVERFLOW = 2;
  localparam int FLAG_UNDERFLOW = 3;
  localparam logic [3:0] FLAGS_RESET = 4'h0;
  localparam logic [7:0] IRQ_EN_RESET = 8'h00;
  localparam logic [7:0] VALID_MASK_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [63:0] CODE_RESET = 64'h1E8B_6A3D_E0E9_B222;

  // ---------------------------------------------------------------
  // spreading lengths
  // ---------------------------------------------------------------
  localparam logic [5:0] CHIPS_LONG_LAST = 6'h3F;
  localparam logic [5:0] CHIPS_SHORT_LAST = 6'h1F;

  // shifter states
  typedef enum logic [1:0] {
    TSF_IDLE = 2'b00,
    TSF_SHIFT = 2'b01,
    TSF_WAIT = 2'b10
  } tsf_state_e;

endpackage

// [hdl/tsf_tx_serializer.sv]
module tsf_tx_serializer (
  input wire logic mclk,
  input wire logic sys_rst,
  // register access port
  input wire logic [5:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // mode bits from the mode register
  input wire logic tx_mode_en,
  input wire logic rx_mode_en,
  input wire logic short_code,
  // chip stream toward the modulator
  output logic chip_valid,
  output logic chip_data,
  output logic chip_preamble,
  input wire logic chip_ready,
  // interrupt
  output logic tx_irq
);

  // -----------------------------------------------------------------
  // registers and state
  // -----------------------------------------------------------------
  logic [7:0] irq_en;
  logic [7:0] valid_mask;
  logic [63:0] spreading_code_bytes;
  logic [3:0] flags;
  logic flag_underflow;
  logic flag_overflow;
  logic flag_done;
  logic flag_empty;
  logic [7:0] hold_data;
  logic [7:0] hold_valid;
  logic hold_full;
  logic [7:0] sh_data;
  logic [7:0] sh_valid;
  logic [5:0] chip_cnt;
  logic sent_any;
  tsf_pkg::tsf_state_e state;

  logic tx_mode;
  logic wr_data;
  logic rd_flags;
  logic load;
  logic bit_end;
  logic byte_end;
  logic buf_in_valid;
  logic buf_in_ready;
  logic [1:0] buf_in_data;
  logic [1:0] buf_out_data;
  logic [5:0] chip_last;
  logic cur_bit;
  logic cur_valid;
  logic code_chip;
  logic underflow_set;
  logic overflow_set;
  logic done_set;

  // byte lane of the spreading code at a given address
  function automatic logic [2:0] code_lane(input logic [5:0] addr);
    logic [5:0] diff;
    diff = addr - tsf_pkg::ADDR_CODE_FIRST;
    return diff[2:0];
  endfunction

  // address falls inside the spreading code window
  function automatic logic in_code(input logic [5:0] addr);
    return (addr >= tsf_pkg::ADDR_CODE_FIRST) && (addr <= tsf_pkg::ADDR_CODE_LAST);
  endfunction

  // -----------------------------------------------------------------
  // decode
  // -----------------------------------------------------------------
  // transmit mode only while transmit is on and receive is off
  assign tx_mode = tx_mode_en && !rx_mode_en;
  assign wr_data = reg_wr && (reg_addr == tsf_pkg::ADDR_TX_DATA_BYTE);
  assign rd_flags = reg_rd && (reg_addr == tsf_pkg::ADDR_TX_EVENT_FLAGS);
  assign chip_last = short_code ? tsf_pkg::CHIPS_SHORT_LAST : tsf_pkg::CHIPS_LONG_LAST;

  // current bit and its spreading chip
  assign cur_bit = sh_data[0];
  assign cur_valid = sh_valid[0];
  assign code_chip = spreading_code_bytes[chip_cnt];

  // a bit ends on its last chip being accepted
  assign bit_end = (state == tsf_pkg::TSF_SHIFT) && buf_in_ready && (chip_cnt == chip_last);
  // the byte ends when no valid bits remain after this shift
  assign byte_end = bit_end && ((sh_valid >> 1) == 8'h00);
  // shifter takes the held byte when idle or waiting, or at the end of a byte
  assign load = tx_mode && hold_full && ((state != tsf_pkg::TSF_SHIFT) || byte_end);

  // chips: data bit 1 sends code, 0 sends inverse; preamble sends code
  assign buf_in_valid = (state == tsf_pkg::TSF_SHIFT);
  assign buf_in_data[0] = cur_valid ? (code_chip ^ ~cur_bit) : code_chip;
  assign buf_in_data[1] = ~cur_valid;

  // -----------------------------------------------------------------
  // output buffer
  // -----------------------------------------------------------------
  tsf_pair_buf #(
    .WIDTH(2)
  ) u_buf (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .in_valid(buf_in_valid),
    .in_ready(buf_in_ready),
    .in_data(buf_in_data),
    .out_valid(chip_valid),
    .out_ready(chip_ready),
    .out_data(buf_out_data)
  );

  assign chip_data = buf_out_data[0];
  assign chip_preamble = buf_out_data[1];

  // -----------------------------------------------------------------
  // software registers
  // -----------------------------------------------------------------
  // interrupt enable and valid mask
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_en <= tsf_pkg::IRQ_EN_RESET;
      valid_mask <= tsf_pkg::VALID_MASK_RESET;
    end else if (reg_wr) begin
      if (reg_addr == tsf_pkg::ADDR_TX_IRQ_EN) begin
        irq_en <= {4'h0, reg_wdata[3:0]};
      end
      if (reg_addr == tsf_pkg::ADDR_TX_BIT_VALID_MASK) begin
        valid_mask <= reg_wdata;
      end
    end
  end

  // spreading code bytes, low byte at the lowest address
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      spreading_code_bytes <= tsf_pkg::CODE_RESET;
    end else if (reg_wr && in_code(reg_addr)) begin
      spreading_code_bytes[code_lane(reg_addr)*8 +: 8] <= reg_wdata;
    end
  end

  // holding register: written by host, emptied by the shifter
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      hold_data <= tsf_pkg::DATA_RESET;
      hold_valid <= tsf_pkg::VALID_MASK_RESET;
      hold_full <= 1'b0;
    end else begin
      if (wr_data) begin
        hold_data <= reg_wdata;
        hold_valid <= valid_mask;
        hold_full <= 1'b1;
      end else if (load || !tx_mode) begin
        hold_full <= 1'b0;
      end
    end
  end

  // -----------------------------------------------------------------
  // shifter
  // -----------------------------------------------------------------
  // state, shift and chip count
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= tsf_pkg::TSF_IDLE;
      sh_data <= tsf_pkg::DATA_RESET;
      sh_valid <= tsf_pkg::VALID_MASK_RESET;
      chip_cnt <= 6'h00;
    end else if (!tx_mode) begin
      state <= tsf_pkg::TSF_IDLE;
      chip_cnt <= 6'h00;
    end else begin
      case (state)
        tsf_pkg::TSF_IDLE, tsf_pkg::TSF_WAIT: begin
          if (load) begin
            sh_data <= hold_data;
            sh_valid <= hold_valid;
            chip_cnt <= 6'h00;
            state <= (hold_valid == 8'h00) ? tsf_pkg::TSF_WAIT : tsf_pkg::TSF_SHIFT;
          end
        end
        tsf_pkg::TSF_SHIFT: begin
          if (buf_in_ready) begin
            chip_cnt <= bit_end ? 6'h00 : chip_cnt + 6'h01;
          end
          if (load) begin
            sh_data <= hold_data;
            sh_valid <= hold_valid;
            state <= (hold_valid == 8'h00) ? tsf_pkg::TSF_WAIT : tsf_pkg::TSF_SHIFT;
          end else if (byte_end) begin
            state <= tsf_pkg::TSF_WAIT;
          end else if (bit_end) begin
            sh_data <= sh_data >> 1;
            sh_valid <= sh_valid >> 1;
          end
        end
        default: begin
          state <= tsf_pkg::TSF_IDLE;
        end
      endcase
    end
  end

  // remembers that a bit went out since transmit mode began
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      sent_any <= 1'b0;
    end else if (!tx_mode) begin
      sent_any <= 1'b0;
    end else if (bit_end) begin
      sent_any <= 1'b1;
    end
  end

  // -----------------------------------------------------------------
  // event flags
  // -----------------------------------------------------------------
  // set conditions; a set in the cycle of a clearing read wins
  assign underflow_set = (state == tsf_pkg::TSF_WAIT) && !hold_full && buf_in_ready && sent_any;
  assign overflow_set = wr_data && hold_full && !load;
  assign done_set = byte_end && !hold_full;

  // underflow: waiting for data after a sent bit
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      flag_underflow <= tsf_pkg::FLAGS_RESET[tsf_pkg::FLAG_UNDERFLOW];
    end else if (!tx_mode) begin
      flag_underflow <= tsf_pkg::FLAGS_RESET[tsf_pkg::FLAG_UNDERFLOW];
    end else if (underflow_set) begin
      flag_underflow <= 1'b1;
    end else if (rd_flags) begin
      flag_underflow <= 1'b0;
    end
  end

  // overflow: new byte while the previous is still held
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      flag_overflow <= tsf_pkg::FLAGS_RESET[tsf_pkg::FLAG_OVERFLOW];
    end else if (!tx_mode) begin
      flag_overflow <= tsf_pkg::FLAGS_RESET[tsf_pkg::FLAG_OVERFLOW];
    end else if (overflow_set) begin
      flag_overflow <= 1'b1;
    end else if (rd_flags) begin
      flag_overflow <= 1'b0;
    end
  end

  // done: a byte ended and nothing waits
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      flag_done <= tsf_pkg::FLAGS_RESET[tsf_pkg::FLAG_DONE];
    end else if (!tx_mode) begin
      flag_done <= tsf_pkg::FLAGS_RESET[tsf_pkg::FLAG_DONE];
    end else if (done_set) begin
      flag_done <= 1'b1;
    end else if (rd_flags) begin
      flag_done <= 1'b0;
    end
  end

  // empty: a data write clears, a load sets; reads leave it alone
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      flag_empty <= tsf_pkg::FLAGS_RESET[tsf_pkg::FLAG_EMPTY];
    end else if (!tx_mode) begin
      flag_empty <= tsf_pkg::FLAGS_RESET[tsf_pkg::FLAG_EMPTY];
    end else if (wr_data) begin
      flag_empty <= 1'b0;
    end else if (load) begin
      flag_empty <= 1'b1;
    end
  end

  // status view in register bit order: underflow, overflow, done, empty
  assign flags = {flag_underflow, flag_overflow, flag_done, flag_empty};

  // -----------------------------------------------------------------
  // read path and interrupt
  // -----------------------------------------------------------------
  // registered read data, zero for unmapped or write-only addresses
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      if (reg_addr == tsf_pkg::ADDR_TX_EVENT_FLAGS) begin
        reg_rdata <= tx_mode ? {4'h0, flags} : 8'h00;
      end else if (reg_addr == tsf_pkg::ADDR_TX_IRQ_EN) begin
        reg_rdata <= irq_en;
      end else if (reg_addr == tsf_pkg::ADDR_TX_BIT_VALID_MASK) begin
        reg_rdata <= valid_mask;
      end else if (in_code(reg_addr)) begin
        reg_rdata <= spreading_code_bytes[code_lane(reg_addr)*8 +: 8];
      end else begin
        reg_rdata <= 8'h00;
      end
    end
  end

  // level interrupt from enabled flags
  assign tx_irq = |(flags & irq_en[3:0]);

endmodule

// [tb/tsf_chip_sink.sv]
module tsf_chip_sink (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic chip_valid,
  input wire logic chip_data,
  input wire logic chip_preamble,
  input wire logic slow,
  output logic chip_ready
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0] got_q[$];

  // modulator: records chips; when slow it takes one every other cycle
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst)
      chip_ready <= 1'b0;
    else begin
      if (chip_valid && chip_ready)
        got_q.push_back({chip_preamble, chip_data});
      chip_ready <= #1 (slow ? ~chip_ready : 1'b1);
    end
  end
endmodule

// [tb/tsf_tx_serializer_props.sv]
module tsf_tx_serializer_props (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [5:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic tx_mode_en,
  input wire logic rx_mode_en,
  input wire logic chip_valid,
  input wire logic chip_data,
  input wire logic chip_preamble,
  input wire logic chip_ready,
  input wire logic tx_irq
);
  timeunit 1ns;
  timeprecision 100ps;
  logic txm;
  logic sent_any;

  // ----------------------------------------
  // helper state
  // ----------------------------------------
  // transmit mode as the flags see it
  assign txm = tx_mode_en & ~rx_mode_en;

  // remembers that the modulator took a chip in this transmit session
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst)
      sent_any <= 1'b0;
    else if (!txm)
      sent_any <= 1'b0;
    else if (chip_valid && chip_ready)
      sent_any <= 1'b1;
  end

  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);

  chk_status_rsvd: assert property (
    reg_rd && reg_addr == 6'h0E |=> reg_rdata[7:4] == 4'h0)
    else $error("status upper bits set");
  chk_idle_status: assert property (
    reg_rd && reg_addr == 6'h0E && !txm && !$past(txm) |=> reg_rdata == 8'h00)
    else $error("status not zero outside transmit");
  chk_data_readback: assert property (
    reg_rd && reg_addr == 6'h0F |=> reg_rdata == 8'h00)
    else $error("data register readable");
  chk_mask_rw: assert property (
    (reg_wr && reg_addr == 6'h10) ##1 (reg_rd && reg_addr == 6'h10)
    |=> reg_rdata == $past(reg_wdata, 2)) else $error("mask readback wrong");
  chk_empty_clear: assert property (
    (reg_wr && reg_addr == 6'h0F && txm) ##1 (reg_rd && reg_addr == 6'h0E && txm)
    |=> !reg_rdata[0]) else $error("empty not cleared by write");
  chk_first_bit: assert property (
    reg_rd && reg_addr == 6'h0E && !sent_any |=> !reg_rdata[3] && !reg_rdata[1])
    else $error("flag before any bit sent");
  chk_irq_flags: assert property (
    (reg_rd && reg_addr == 6'h0E && txm) ##1 (reg_rdata[3:0] == 4'h0) |-> !$past(tx_irq))
    else $error("interrupt without flag");
  chk_chip_hold: assert property (
    (chip_valid && !chip_ready && txm) ##1 txm
    |-> chip_valid && $stable(chip_data) && $stable(chip_preamble))
    else $error("chip dropped during stall");
endmodule

bind tsf_tx_serializer tsf_tx_serializer_props i_tsf_tx_serializer_props (
  .mclk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .tx_mode_en,
  .rx_mode_en, .chip_valid, .chip_data, .chip_preamble, .chip_ready, .tx_irq);

// [tb/tsf_tx_serializer_tb.sv]
module tsf_tx_serializer_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk, sys_rst, reg_wr, reg_rd, tx_mode_en, rx_mode_en, short_code, slow;
  logic chip_valid, chip_data, chip_preamble, chip_ready, tx_irq;
  logic [5:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  logic [63:0] code = 64'h1E8B_6A3D_E0E9_B222;
  logic [1:0] exp_q[$];
  int num_errors = 0;
  int check_count = 0;

  tsf_tx_serializer i_tsf_tx_serializer (.mclk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .tx_mode_en, .rx_mode_en, .short_code, .chip_valid, .chip_data,
    .chip_preamble, .chip_ready, .tx_irq);
  tsf_chip_sink i_tsf_chip_sink (.mclk, .sys_rst, .chip_valid, .chip_data, .chip_preamble,
    .slow, .chip_ready);

  // ----------------------------------------
  // clock and helpers
  // ----------------------------------------
  initial begin
    mclk = 0;
    forever #4 mclk = ~mclk;
  end

  task automatic chk(logic [15:0] got, logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // write strobe stays up so a following access can be back to back
  task automatic wr(logic [5:0] a, logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1;
    @(posedge mclk) #1;
  endtask

  task automatic rd(logic [5:0] a, logic [7:0] m, logic [7:0] e);
    reg_wr = 0;
    reg_addr = a;
    reg_rd = 1;
    @(posedge mclk) #1;
    reg_rd = 0;
    @(posedge mclk) #1;
    chk(reg_rdata & m, e);
  endtask

  task automatic idle();
    reg_wr = 0;
    @(posedge mclk) #1;
  endtask

  // expected chips of one byte, up to its last valid bit
  task automatic add_byte(logic [7:0] d, logic [7:0] m);
    int last;
    last = 0;
    for (int i = 0; i < 8; i++) if (m[i]) last = i;
    for (int i = 0; i <= last; i++)
      for (int j = 0; j < (short_code ? 32 : 64); j++)
        exp_q.push_back(m[i] ? {1'b0, code[j] ~^ d[i]} : {1'b1, code[j]});
  endtask

  // waits for the stream, then compares it chip by chip
  task automatic drain();
    int k;
    reg_wr = 0;
    for (k = 0; k < 5000 && i_tsf_chip_sink.got_q.size() < exp_q.size(); k++) @(posedge mclk);
    repeat (8) @(posedge mclk);
    #1;
    chk(16'(i_tsf_chip_sink.got_q.size()), 16'(exp_q.size()));
    foreach (exp_q[n]) chk({6'h0, i_tsf_chip_sink.got_q[n]}, {6'h0, exp_q[n]});
    i_tsf_chip_sink.got_q.delete();
    exp_q.delete();
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // watchdog against a hung stream
  initial begin
    repeat (20000) @(posedge mclk);
    num_errors++;
    stop_test();
  end

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    sys_rst = 1;
    {reg_wr, reg_rd, tx_mode_en, rx_mode_en, short_code, slow} = 6'h00;
    reg_addr = 6'h00;
    reg_wdata = 8'h00;
    repeat (12) @(posedge mclk);
    #1;
    sys_rst = 0;
    for (int i = 0; i < 8; i++) rd(6'h11 + 6'(i), 8'hFF, code[8*i +: 8]);
    wr(6'h18, 8'h3C);
    code[63:56] = 8'h3C;
    rd(6'h18, 8'hFF, 8'h3C);
    wr(6'h0E, 8'hFF);
    rd(6'h0E, 8'hFF, 8'h00);
    rd(6'h0F, 8'hFF, 8'h00);
    rd(6'h30, 8'hFF, 8'h00);
    wr(6'h0D, 8'hFF);
    rd(6'h0D, 8'hFF, 8'h0F);
    wr(6'h10, 8'h0B);
    rd(6'h10, 8'hFF, 8'h0B);
    $display("test registers done");
    tx_mode_en = 1;
    short_code = 1;
    slow = 1;
    add_byte(8'h65, 8'h0B);
    wr(6'h0F, 8'h65);
    rd(6'h0E, 8'hFF, 8'h00);
    drain();
    chk({7'h0, tx_irq}, 8'h01);
    rd(6'h0E, 8'h0F, 8'h0B);
    rd(6'h0E, 8'h06, 8'h00);
    wr(6'h0D, 8'h00);
    idle();
    chk({7'h0, tx_irq}, 8'h00);
    rd(6'h0E, 8'h01, 8'h01);
    $display("test short byte done");
    short_code = 0;
    slow = 0;
    wr(6'h10, 8'h01);
    add_byte(8'h01, 8'h01);
    add_byte(8'h00, 8'h01);
    wr(6'h0F, 8'h01);
    repeat (4) idle();
    wr(6'h0F, 8'h01);
    wr(6'h0F, 8'h00);
    rd(6'h0E, 8'h05, 8'h04);
    drain();
    $display("test overflow done");
    rx_mode_en = 1;
    idle();
    rd(6'h0E, 8'hFF, 8'h00);
    $display("test mode exit done");
    stop_test();
  end
endmodule
